// ==== rtl/dtio_pkg.sv ====
// Package of the digital timing connector mux.
// Assumes one 100 MHz clock; no software registers reach this block.
package dtio_pkg;
    // Digital line count and counter direction lines
    localparam int unsigned GP_LINES        = 8;
    localparam int unsigned DIR_LINE_A      = 6;
    localparam int unsigned DIR_LINE_B      = 7;
    // Programmable function pin count and roles
    localparam int unsigned PFI_PINS        = 10;
    localparam int unsigned PFI_ACQ_START   = 0;
    localparam int unsigned PFI_PRETRIGGER_PIN     = 1;
    localparam int unsigned PFI_CNTB_SRC    = 3;
    localparam int unsigned PFI_CNTB_GATE   = 4;
    localparam int unsigned PFI_WAVE_START  = 6;
    localparam int unsigned PFI_INPUT_ONLY  = 7;
    localparam int unsigned PFI_CNTA_SRC    = 8;
    localparam int unsigned PFI_CNTA_GATE   = 9;
    // Reset values
    localparam logic [9:0]  PFI_OE_RESET    = 10'h000;
    localparam logic [7:0]  GP_OE_RESET     = 8'h00;
    localparam logic        STROBE_N_RESET  = 1'h1;
    localparam logic        RESERVED_LEVEL  = 1'h1;
endpackage

// ==== rtl/dtio_connector.sv ====
// Digital connector mux: digital lines, strobe, function pins, counter pins.
// Assumes all inputs are synchronous to i_clk; the timing engines sit outside.
`timescale 1ns/1ps
`default_nettype none
module dtio_connector (
    input  wire logic       i_clk,                // 100 MHz clock
    input  wire logic       i_arst_n,             // Async reset, active low
    input  wire logic [7:0] i_gp_line_out,        // Digital line drive values
    input  wire logic [7:0] i_gp_line_oe,         // Digital line direction, 1 = out
    input  wire logic [7:0] i_gp_digital_line,    // Digital line pin levels
    output logic      [7:0] o_gp_digital_line,    // Digital line pin drive
    output logic      [7:0] o_gp_digital_line_oe, // Digital line enables
    output logic      [7:0] o_gp_line_in,         // Sampled digital lines
    input  wire logic       i_dir_sel_a,          // Counter A direction from line 6
    input  wire logic       i_dir_sel_b,          // Counter B direction from line 7
    output logic            o_counter_a_up,       // Counter A count direction
    output logic            o_counter_b_up,       // Counter B count direction
    output logic            o_reserved_high_out,  // Reserved pin
    input  wire logic       i_strobe_toggle,      // Software toggle pulse
    output logic            o_sw_strobe_n,        // External strobe pin
    input  wire logic [9:0] i_pfi_out_sel,        // Function pin output role select
    input  wire logic [9:0] i_prog_function_pin,  // Function pin levels
    output logic      [9:0] o_prog_function_pin,  // Function pin drive
    output logic      [9:0] o_prog_function_pin_oe, // Function pin enables
    output logic      [9:0] o_pfi_in,             // Function inputs, 0 if output
    output logic            o_external_start_trigger, // Start trigger source
    input  wire logic       i_acq_start_trigger,  // Internal start trigger
    input  wire logic       i_pretrigger_pin_mode,       // 1 = pretriggered acquisition
    input  wire logic       i_acq_pretrigger_pin_stop,   // Posttrigger conversions begun
    input  wire logic       i_convert_pulse,      // One per ADC conversion
    output logic            o_convert_n,          // Conversion strobe pin
    input  wire logic       i_update_pulse,       // One per DAC conversion
    output logic            o_update_n,           // Update strobe pin
    input  wire logic       i_counter_a_src,      // Selected counter A source
    input  wire logic       i_counter_a_gate,     // Selected counter A gate
    input  wire logic       i_counter_b_src,      // Selected counter B source
    input  wire logic       i_counter_b_gate,     // Selected counter B gate
    input  wire logic       i_counter_a_out,      // Counter A output
    input  wire logic       i_counter_b_out,      // Counter B output
    output logic            o_counter_a_out,      // Counter A output pin
    output logic            o_counter_b_out,      // Counter B output pin
    input  wire logic       i_waveform_start_trigger, // Waveform start level
    input  wire logic       i_freq_gen_out,       // Frequency generator
    output logic            o_freq_gen_out        // Frequency output pin
);

    // Function pin drive candidates by role
    wire logic [9:0] pfi_drive;
    wire logic [9:0] pfi_out_ok;
    wire logic [9:0] pfi_role_mask;
    wire logic       pretrigger_pin_level;

    // One-hot mask of a function pin position
    function automatic logic [9:0] f_pin_bit(input int unsigned pos);
        f_pin_bit = 10'h001 << pos;
    endfunction

    // Pretrigger level only in pretriggered acquisitions
    assign pretrigger_pin_level = i_pretrigger_pin_mode & i_acq_pretrigger_pin_stop;

    assign pfi_drive = {i_counter_a_gate,
                        i_counter_a_src,
                        1'h0,
                        i_waveform_start_trigger,
                        1'h0,
                        i_counter_b_gate,
                        i_counter_b_src,
                        1'h0,
                        pretrigger_pin_level,
                        i_acq_start_trigger};

    // Pins that own an output role; 2, 5 and 7 never drive
    assign pfi_role_mask = f_pin_bit(dtio_pkg::PFI_ACQ_START)
                         | f_pin_bit(dtio_pkg::PFI_PRETRIGGER_PIN)
                         | f_pin_bit(dtio_pkg::PFI_CNTB_SRC)
                         | f_pin_bit(dtio_pkg::PFI_CNTB_GATE)
                         | f_pin_bit(dtio_pkg::PFI_WAVE_START)
                         | f_pin_bit(dtio_pkg::PFI_CNTA_SRC)
                         | f_pin_bit(dtio_pkg::PFI_CNTA_GATE);
    assign pfi_out_ok = i_pfi_out_sel & pfi_role_mask;

    // Digital lines and direction controls
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_gp_digital_line    <= 8'h00;
            o_gp_digital_line_oe <= dtio_pkg::GP_OE_RESET;
            o_gp_line_in         <= 8'h00;
            o_counter_a_up       <= 1'h0;
            o_counter_b_up       <= 1'h0;
        end else begin
            o_gp_digital_line    <= i_gp_line_out;
            o_gp_digital_line_oe <= i_gp_line_oe;
            o_gp_line_in         <= i_gp_digital_line;
            o_counter_a_up       <= i_dir_sel_a & i_gp_digital_line[dtio_pkg::DIR_LINE_A];
            o_counter_b_up       <= i_dir_sel_b & i_gp_digital_line[dtio_pkg::DIR_LINE_B];
        end
    end

    // Reserved pin, software strobe and timing strobes
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reserved_high_out <= dtio_pkg::RESERVED_LEVEL;
            o_sw_strobe_n       <= dtio_pkg::STROBE_N_RESET;
            o_convert_n         <= 1'h1;
            o_update_n          <= 1'h1;
        end else begin
            o_reserved_high_out <= dtio_pkg::RESERVED_LEVEL;
            if (i_strobe_toggle) begin
                o_sw_strobe_n <= ~o_sw_strobe_n;
            end
            o_convert_n <= ~i_convert_pulse;
            o_update_n  <= ~i_update_pulse;
        end
    end

    // Function pins, counter and frequency pins
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prog_function_pin      <= 10'h000;
            o_prog_function_pin_oe   <= dtio_pkg::PFI_OE_RESET;
            o_pfi_in                 <= 10'h000;
            o_external_start_trigger <= 1'h0;
            o_counter_a_out          <= 1'h0;
            o_counter_b_out          <= 1'h0;
            o_freq_gen_out           <= 1'h0;
        end else begin
            o_prog_function_pin      <= pfi_drive & pfi_out_ok;
            o_prog_function_pin_oe   <= pfi_out_ok;
            o_pfi_in                 <= i_prog_function_pin & ~pfi_out_ok;
            o_external_start_trigger <= i_prog_function_pin[dtio_pkg::PFI_ACQ_START]
                                        & ~pfi_out_ok[dtio_pkg::PFI_ACQ_START];
            o_counter_a_out          <= i_counter_a_out;
            o_counter_b_out          <= i_counter_b_out;
            o_freq_gen_out           <= i_freq_gen_out;
        end
    end

    // Checks
    property p_reserved;
        @(posedge i_clk) disable iff (!i_arst_n) ##1 o_reserved_high_out;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved pin low");

    property p_strobe;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_strobe_toggle |=> o_sw_strobe_n != $past(o_sw_strobe_n);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not toggled");

    property p_convert;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_convert_pulse ##1 !i_convert_pulse |-> !o_convert_n ##1 o_convert_n;
    endproperty
    a_convert: assert property (p_convert) else $error("convert strobe wrong");

    property p_update;
        @(posedge i_clk) disable iff (!i_arst_n) i_update_pulse |=> !o_update_n;
    endproperty
    a_update: assert property (p_update) else $error("update strobe missing");

    property p_oe_off;
        @(posedge i_clk) disable iff (!i_arst_n)
            !i_pfi_out_sel[dtio_pkg::PFI_CNTA_SRC] |=>
                !o_prog_function_pin_oe[dtio_pkg::PFI_CNTA_SRC];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven as input");

    property p_pfi7;
        @(posedge i_clk) disable iff (!i_arst_n)
            ##1 !o_prog_function_pin_oe[dtio_pkg::PFI_INPUT_ONLY];
    endproperty
    a_pfi7: assert property (p_pfi7) else $error("input-only pin driven");

    property p_pretrigger_pin;
        @(posedge i_clk) disable iff (!i_arst_n)
            !i_pretrigger_pin_mode |=> !o_prog_function_pin[dtio_pkg::PFI_PRETRIGGER_PIN];
    endproperty
    a_pretrigger_pin: assert property (p_pretrigger_pin) else $error("pretrigger in post mode");

    property p_start_in;
        @(posedge i_clk) disable iff (!i_arst_n)
            !i_pfi_out_sel[0] && i_prog_function_pin[0] |=> o_external_start_trigger;
    endproperty
    a_start_in: assert property (p_start_in) else $error("start input lost");

    property p_cntb_mirror;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_CNTB_GATE] |=>
                o_prog_function_pin[dtio_pkg::PFI_CNTB_GATE] == $past(i_counter_b_gate);
    endproperty
    a_cntb_mirror: assert property (p_cntb_mirror) else $error("gate not mirrored");

    property p_wave;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_WAVE_START] && $rose(i_waveform_start_trigger)
                |=> $rose(o_prog_function_pin[dtio_pkg::PFI_WAVE_START]);
    endproperty
    a_wave: assert property (p_wave) else $error("waveform edge lost");

    // Checks of digital lines and direction controls
    property p_gp_drive;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_gp_digital_line == $past(i_gp_line_out)
                  && o_gp_digital_line_oe == $past(i_gp_line_oe);
    endproperty
    a_gp_drive: assert property (p_gp_drive) else $error("digital line drive lost");

    property p_gp_in;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_gp_line_in == $past(i_gp_digital_line);
    endproperty
    a_gp_in: assert property (p_gp_in) else $error("digital line input lost");

    property p_dir_a;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_counter_a_up
                == ($past(i_dir_sel_a) && $past(i_gp_digital_line[dtio_pkg::DIR_LINE_A]));
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("counter A direction wrong");

    property p_dir_b;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_counter_b_up
                == ($past(i_dir_sel_b) && $past(i_gp_digital_line[dtio_pkg::DIR_LINE_B]));
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("counter B direction wrong");

    // Checks of strobes
    property p_strobe_hold;
        @(posedge i_clk) disable iff (!i_arst_n)
            !i_strobe_toggle |=> $stable(o_sw_strobe_n);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved alone");

    property p_convert_fall;
        @(posedge i_clk) disable iff (!i_arst_n)
            $rose(i_convert_pulse) |=> $fell(o_convert_n);
    endproperty
    a_convert_fall: assert property (p_convert_fall) else $error("convert edge lost");

    property p_update_idle;
        @(posedge i_clk) disable iff (!i_arst_n)
            !i_update_pulse |=> o_update_n;
    endproperty
    a_update_idle: assert property (p_update_idle) else $error("update strobe stuck");

    // Checks of function pin roles
    property p_start_out;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_ACQ_START] |=>
                o_prog_function_pin_oe[dtio_pkg::PFI_ACQ_START]
                && o_prog_function_pin[dtio_pkg::PFI_ACQ_START] == $past(i_acq_start_trigger);
    endproperty
    a_start_out: assert property (p_start_out) else $error("start output lost");

    property p_start_block;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_ACQ_START] |=> !o_external_start_trigger;
    endproperty
    a_start_block: assert property (p_start_block) else $error("start input while out");

    property p_pretrigger_pin_rise;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_PRETRIGGER_PIN] && i_pretrigger_pin_mode
                && $rose(i_acq_pretrigger_pin_stop)
                |=> $rose(o_prog_function_pin[dtio_pkg::PFI_PRETRIGGER_PIN]);
    endproperty
    a_pretrigger_pin_rise: assert property (p_pretrigger_pin_rise) else $error("pretrigger edge lost");

    property p_cntb_src;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_CNTB_SRC] |=>
                o_prog_function_pin[dtio_pkg::PFI_CNTB_SRC] == $past(i_counter_b_src);
    endproperty
    a_cntb_src: assert property (p_cntb_src) else $error("source B not mirrored");

    property p_cnta_src;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_CNTA_SRC] |=>
                o_prog_function_pin[dtio_pkg::PFI_CNTA_SRC] == $past(i_counter_a_src);
    endproperty
    a_cnta_src: assert property (p_cnta_src) else $error("source A not mirrored");

    property p_cnta_gate;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_CNTA_GATE] |=>
                o_prog_function_pin[dtio_pkg::PFI_CNTA_GATE] == $past(i_counter_a_gate);
    endproperty
    a_cnta_gate: assert property (p_cnta_gate) else $error("gate A not mirrored");

    property p_wave_oe;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_WAVE_START] |=>
                o_prog_function_pin_oe[dtio_pkg::PFI_WAVE_START];
    endproperty
    a_wave_oe: assert property (p_wave_oe) else $error("waveform pin not driven");

    property p_no_role;
        @(posedge i_clk) disable iff (!i_arst_n)
            ##1 !o_prog_function_pin_oe[2] && !o_prog_function_pin_oe[5];
    endproperty
    a_no_role: assert property (p_no_role) else $error("roleless pin driven");

    // Checks of function inputs and dedicated pins
    property p_pfi7_in;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_pfi_in[dtio_pkg::PFI_INPUT_ONLY]
                == $past(i_prog_function_pin[dtio_pkg::PFI_INPUT_ONLY]);
    endproperty
    a_pfi7_in: assert property (p_pfi7_in) else $error("input-only pin lost");

    property p_pfi_in_out;
        @(posedge i_clk) disable iff (!i_arst_n)
            i_pfi_out_sel[dtio_pkg::PFI_CNTA_GATE] |=> !o_pfi_in[dtio_pkg::PFI_CNTA_GATE];
    endproperty
    a_pfi_in_out: assert property (p_pfi_in_out) else $error("output pin seen as input");

    property p_counter_out;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_counter_a_out == $past(i_counter_a_out)
                  && o_counter_b_out == $past(i_counter_b_out);
    endproperty
    a_counter_out: assert property (p_counter_out) else $error("counter output lost");

    property p_freq;
        @(posedge i_clk) disable iff (!i_arst_n)
            1'h1 |=> o_freq_gen_out == $past(i_freq_gen_out);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency output lost");

endmodule
`default_nettype wire

// ==== bench/dtio_ext_inst.sv ====
// Model of the instruments and accessories wired to the digital connector.
// Assumes the device drive and enable come straight from the connector mux.
`timescale 1ns/1ps
`default_nettype none
module dtio_ext_inst #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_dev_val, // Device drive values
    input  wire logic [W-1:0] i_dev_oe,  // Device enables
    input  wire logic [W-1:0] i_ext_val, // Instrument drive values
    input  wire logic [W-1:0] i_ext_en,  // Instrument wants to drive
    output logic      [W-1:0] o_pin      // Resolved pin level
);
    // Device wins where enabled, instrument only drives free pins, else pull-up
    assign o_pin = (i_dev_oe & i_dev_val) | (~i_dev_oe & i_ext_en & i_ext_val)
                 | (~i_dev_oe & ~i_ext_en);
endmodule
`default_nettype wire

// ==== bench/test_daq_timing_io_connector.sv ====
// Self-checking bench of the digital connector mux, random with one corner run.
// Assumes one 100 MHz clock and outputs registered one cycle after inputs.
`timescale 1ns/1ps
`default_nettype none
module test_daq_timing_io_connector;
    logic        i_clk = 1'h0;
    logic        i_arst_n = 1'h0;
    logic        sn = 1'h1;
    logic [15:0] st = 16'h0000;
    logic [7:0]  gout = 8'h00, goe_i = 8'h00, gxv = 8'h00, gxe = 8'h00;
    logic [9:0]  sel = 10'h000, pxv = 10'h000, pxe = 10'h000;
    wire  [7:0]  gdo, goe, gin, gpin;
    wire  [9:0]  pdo, poe, pin, ppin, ob;
    int          seed = 75966;
    int          error_cnt = 0;
    int          comparisons = 0;

    // Clock at 100 MHz
    always #5 i_clk = ~i_clk;

    dtio_connector dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_gp_line_out(gout),
        .i_gp_line_oe(goe_i), .i_gp_digital_line(gpin), .o_gp_digital_line(gdo),
        .o_gp_digital_line_oe(goe), .o_gp_line_in(gin), .i_dir_sel_a(st[0]),
        .i_dir_sel_b(st[1]), .o_counter_a_up(ob[0]), .o_counter_b_up(ob[1]),
        .o_reserved_high_out(ob[2]), .i_strobe_toggle(st[2]), .o_sw_strobe_n(ob[3]),
        .i_pfi_out_sel(sel), .i_prog_function_pin(ppin), .o_prog_function_pin(pdo),
        .o_prog_function_pin_oe(poe), .o_pfi_in(pin), .o_external_start_trigger(ob[4]),
        .i_acq_start_trigger(st[3]), .i_pretrigger_pin_mode(st[4]), .i_acq_pretrigger_pin_stop(st[5]),
        .i_convert_pulse(st[6]), .o_convert_n(ob[5]), .i_update_pulse(st[7]),
        .o_update_n(ob[6]), .i_counter_a_src(st[8]), .i_counter_a_gate(st[9]),
        .i_counter_b_src(st[10]), .i_counter_b_gate(st[11]), .i_counter_a_out(st[12]),
        .i_counter_b_out(st[13]), .o_counter_a_out(ob[7]), .o_counter_b_out(ob[8]),
        .i_waveform_start_trigger(st[14]), .i_freq_gen_out(st[15]), .o_freq_gen_out(ob[9]));
    dtio_ext_inst #(.W(8)) ext_g (.i_dev_val(gdo), .i_dev_oe(goe), .i_ext_val(gxv),
        .i_ext_en(gxe), .o_pin(gpin));
    dtio_ext_inst #(.W(10)) ext_p (.i_dev_val(pdo), .i_dev_oe(poe), .i_ext_val(pxv),
        .i_ext_en(pxe), .o_pin(ppin));

    // Expected single-bit outputs from sampled inputs
    function automatic logic [9:0] f_ob(logic [15:0] s, logic [7:0] g, logic [9:0] p,
                                        logic [9:0] oe, logic n);
        f_ob = {s[15], s[13], s[12], ~s[7], ~s[6], p[0] & ~oe[0], n, 1'h1,
                g[7] & s[1], g[6] & s[0]};
    endfunction
    // Expected function pin drive values
    function automatic logic [9:0] f_pv(logic [15:0] s);
        f_pv = {s[9], s[8], 1'h0, s[14], 1'h0, s[11], s[10], 1'h0, s[5] & s[4], s[3]};
    endfunction

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Random stimulus; corner mode forces all output roles, strobe and stop high
    task automatic drive(input logic corner);
        logic [31:0] r;
        r = $random(seed);
        st <= corner ? (r[15:0] | 16'h0024) : r[15:0];
        gout <= r[23:16];
        goe_i <= r[31:24];
        r = $random(seed);
        sel <= corner ? 10'h3ff : r[9:0];
        gxv <= r[17:10];
        gxe <= r[25:18];
        r = $random(seed);
        pxv <= r[9:0];
        pxe <= r[19:10];
    endtask

    // Sample at each edge, compare after it; first edge of each run unchecked
    task automatic run(input int n, input logic corner);
        logic [15:0] cs;
        logic [7:0]  cgo, cge, cgp;
        logic [9:0]  cpp, eoe;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            cs = st;
            cgo = gout;
            cge = goe_i;
            cgp = gpin;
            cpp = ppin;
            eoe = sel & 10'h35b;
            drive(corner);
            sn = sn ^ cs[2];
            @(negedge i_clk);
            if (i > 0) begin
                chk("misc", f_ob(cs, cgp, cpp, eoe, sn), ob);
                chk("pfi_oe", eoe, poe);
                chk("pfi_val", f_pv(cs) & eoe, pdo);
                chk("pfi_in", cpp & ~eoe, pin);
                chk("gp_oe", 10'(cge), 10'(goe));
                chk("gp_val", 10'(cgo), 10'(gdo));
                chk("gp_in", 10'(cgp), 10'(gin));
            end
        end
    endtask

    // Reset with quiet inputs, then check reset levels
    task automatic do_reset(input int cyc);
        st <= 16'h0000;
        gout <= 8'h00;
        goe_i <= 8'h00;
        sel <= 10'h000;
        i_arst_n = 1'h0;
        repeat (cyc) @(negedge i_clk);
        chk("rst_ob", 10'h06c, ob);
        chk("rst_oe", 10'h000, poe | 10'(goe));
        i_arst_n = 1'h1;
        sn = 1'h1;
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence with a reset in mid-run
    initial begin
        do_reset(12);
        run(200, 1'h0);
        run(20, 1'h1);
        run(200, 1'h0);
        do_reset(3);
        run(100, 1'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
